// ==== frame_checksum_unit.sv ====
/*
  serial frame checksum unit: ahb-lite slave with a 512-word store,
  computes the lrc of text frames or the crc of binary frames.
  assumes one clock hclk, reset hresetn, single word transfers.
*/
// Overview of operation
// - text frame opens with one colon, 3ah, before the address.
// - station address as two hex chars, high nibble first.
// - function code as two hex chars, high nibble first.
// - n data bytes as 2n hex chars, most significant first.
// - check byte follows data as two hex chars, high first.
// - text frame ends with carriage return then line feed.
// - lrc is two's complement of byte sum, address to data end.
// - crc byte count runs from one to 256; the code also rejects odd counts.
// - byte mode clear: each word gives high then low byte.
// - packed mode: whole checksum stored in one destination word.
// - byte mode set: high bytes ignored, low bytes of n words.
// - byte mode: result in low bytes of two consecutive words.
// - crc low byte in first location, high byte second.
// - rtu mode set selects binary framing with crc.
// - rtu mode clear selects text framing with lrc.
// - lrc stored as two hex chars, high nibble char first.
`timescale 1ns/100ps
module frame_checksum_unit (
  input  wire logic        hclk,        // bus clock, 50 mhz
  input  wire logic        hresetn,     // async reset, active low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write when high
  input  wire logic [2:0]  hsize,       // word only
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready in
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // always ready
  output logic             hresp,       // always okay
  output logic             irq          // level interrupt
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [15:0] mem [checksum_pkg::MEM_WORDS];
  logic [3:0]  ctrl_r;
  logic [8:0]  len_r, src_r, dst_r;
  logic        operr_r, latch_r;
  logic [15:0] errcode_r, result_r;
  logic [1:0]  int_stat_r, int_mask_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic        irq_r;
  logic        mode8_r, rtu_r, end_r;
  checksum_pkg::eng_state_t state_r;
  logic [8:0]  cnt_r;
  logic [15:0] crc_r;
  logic [7:0]  sum_r;
  logic [3:0]  nib_r;
  logic        ph_r;
  logic [1:0]  k_r;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire logic        ap_take  = hsel & htrans[1] & hready;
  wire logic        ap_read  = ap_take & ~hwrite;
  wire logic [11:0] ap_addr  = {haddr[11:2], 2'b00};
  wire logic        wr_mem   = wr_pend_r &
                               wr_addr_r[checksum_pkg::MEM_SEL_BIT];
  wire logic        wr_reg   = wr_pend_r &
                               ~wr_addr_r[checksum_pkg::MEM_SEL_BIT];
  wire logic        busy     = (state_r != checksum_pkg::IDLE);
  wire logic        start    = wr_reg & ~busy &
                               (wr_addr_r == checksum_pkg::CTRL_ADDR) &
                               hwdata[checksum_pkg::CTRL_START];
  wire logic        clr_int  = ap_read &
                               (ap_addr == checksum_pkg::INTSTAT_ADDR);
  wire logic        wr_stat  = wr_reg &
                               (wr_addr_r == checksum_pkg::STATUS_ADDR);
  // mask as it stands after this edge, so irq never lags a mask write
  wire logic        mask_we  = wr_reg & ~busy &
                               (wr_addr_r == checksum_pkg::INTMASK_ADDR);
  wire logic [1:0]  mask_nxt = mask_we ? hwdata[1:0] : int_mask_r;
  wire logic [8:0]  ap_idx   = haddr[10:2];
  wire logic [8:0]  wr_idx   = wr_addr_r[10:2];

  // count must be even and within one to 256
  wire logic        bad_len  = (len_r == 9'h000) |
                               (len_r > checksum_pkg::LEN_MAX) | len_r[0];
  wire logic        go_err   = start & bad_len;
  wire logic        go_run   = start & ~bad_len;

  // status word seen by software
  wire logic [2:0]  status_w = {latch_r, operr_r, busy};

  // read mux, registered in the address phase
  wire logic [31:0] rd_reg =
    (ap_addr == checksum_pkg::CTRL_ADDR)    ? {28'h0, ctrl_r[3:1], 1'b0} :
    (ap_addr == checksum_pkg::LEN_ADDR)     ? {23'h000000, len_r} :
    (ap_addr == checksum_pkg::SRC_ADDR)     ? {23'h000000, src_r} :
    (ap_addr == checksum_pkg::DST_ADDR)     ? {23'h000000, dst_r} :
    (ap_addr == checksum_pkg::STATUS_ADDR)  ? {29'h00000000, status_w} :
    (ap_addr == checksum_pkg::ERRCODE_ADDR) ? {16'h0000, errcode_r} :
    (ap_addr == checksum_pkg::RESULT_ADDR)  ? {16'h0000, result_r} :
    (ap_addr == checksum_pkg::INTSTAT_ADDR) ? {30'h00000000, int_stat_r} :
    (ap_addr == checksum_pkg::INTMASK_ADDR) ? {30'h00000000, int_mask_r} :
    32'h00000000;
  wire logic [31:0] rd_mux = haddr[checksum_pkg::MEM_SEL_BIT] ?
                             {16'h0000, mem[ap_idx]} : rd_reg;

  // ------------------------------------------------------------------
  // source fetch
  // ------------------------------------------------------------------
  // byte mode: one low byte per word; packed: high byte then low byte
  wire logic [8:0]  src_idx  = mode8_r ? src_r + cnt_r
                                       : src_r + {1'b0, cnt_r[8:1]};
  wire logic [15:0] src_word = mem[src_idx];
  wire logic [7:0]  src_byte = (mode8_r | cnt_r[0]) ? src_word[7:0]
                                                    : src_word[15:8];
  wire logic        last     = (cnt_r == len_r - 9'h001);

  // ------------------------------------------------------------------
  // checksum steps
  // ------------------------------------------------------------------
  logic [15:0] crc_nxt;
  logic [7:0]  sum_nxt;
  logic [3:0]  nib_nxt;
  logic        ph_nxt;

  crc16_step u_crc (
    .crc_in  (crc_r),
    .data_in (src_byte),
    .crc_out (crc_nxt)
  );

  lrc_step u_lrc (
    .char_in   (src_byte),
    .sum_in    (sum_r),
    .nib_in    (nib_r),
    .phase_in  (ph_r),
    .sum_out   (sum_nxt),
    .nib_out   (nib_nxt),
    .phase_out (ph_nxt)
  );

  // ------------------------------------------------------------------
  // result placement
  // ------------------------------------------------------------------
  wire logic [7:0]  lrc_val = 8'h00 - sum_r;
  wire logic [7:0]  lrc_hi   = checksum_pkg::hex_enc(lrc_val[7:4]);
  wire logic [7:0]  lrc_lo   = checksum_pkg::hex_enc(lrc_val[3:0]);
  wire logic [7:0]  first_b  = rtu_r ? crc_r[7:0] : lrc_hi;
  wire logic [7:0]  second_b = rtu_r ? crc_r[15:8] : lrc_lo;
  wire logic        add_end = end_r & ~rtu_r;
  wire logic [1:0]  k_last  = mode8_r ? (add_end ? 2'd3 : 2'd1)
                                      : (add_end ? 2'd1 : 2'd0);
  wire logic [8:0]  eng_idx = dst_r + {7'h00, k_r};

  // packed: one word per value; byte mode: low byte of each word
  wire logic [15:0] eng_wdata =
    ~mode8_r ? ((k_r == 2'd0) ? {first_b, second_b}
                              : {checksum_pkg::CHAR_CR,
                                 checksum_pkg::CHAR_LF}) :
    (k_r == 2'd0) ? {8'h00, first_b} :
    (k_r == 2'd1) ? {8'h00, second_b} :
    (k_r == 2'd2) ? {8'h00, checksum_pkg::CHAR_CR} :
                    {8'h00, checksum_pkg::CHAR_LF};
  wire logic        eng_we  = (state_r == checksum_pkg::STORE);
  wire logic        done_ev = eng_we & (k_r == k_last);
  wire logic [15:0] res_w   = rtu_r ? crc_r : {8'h00, lrc_val};

  // interrupt status: set wins over read clear
  wire logic [1:0]  int_set = {go_err, done_ev};
  wire logic [1:0]  int_nxt = (clr_int ? 2'b00 : int_stat_r) | int_set;

  // ------------------------------------------------------------------
  // bus pipeline and read data
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r  <= 32'h00000000;
    end else begin
      wr_pend_r <= ap_take & hwrite;
      wr_addr_r <= ap_addr;
      hrdata_r  <= ap_read ? rd_mux : hrdata_r;
    end
  end

  // ------------------------------------------------------------------
  // word store, engine has priority, bus writes held off while busy
  // ------------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (eng_we) begin
      mem[eng_idx] <= eng_wdata;
    end else if (wr_mem & ~busy) begin
      mem[wr_idx] <= hwdata[15:0];
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= 4'h0;
      len_r      <= 9'h000;
      src_r      <= 9'h000;
      dst_r      <= 9'h000;
      int_mask_r <= 2'b00;
    end else if (wr_reg & ~busy) begin
      if (wr_addr_r == checksum_pkg::CTRL_ADDR)    ctrl_r     <= hwdata[3:0];
      if (wr_addr_r == checksum_pkg::LEN_ADDR)     len_r      <= hwdata[8:0];
      if (wr_addr_r == checksum_pkg::SRC_ADDR)     src_r      <= hwdata[8:0];
      if (wr_addr_r == checksum_pkg::DST_ADDR)     dst_r      <= hwdata[8:0];
      if (wr_addr_r == checksum_pkg::INTMASK_ADDR) int_mask_r <= hwdata[1:0];
    end
  end

  // ------------------------------------------------------------------
  // error flags, code, result and interrupt
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      operr_r    <= 1'b0;
      latch_r    <= 1'b0;
      errcode_r  <= 16'h0000;
      result_r   <= 16'h0000;
      int_stat_r <= 2'b00;
      irq_r      <= 1'b0;
    end else begin
      // operation flag follows each start, latch stays until cleared
      operr_r    <= start ? bad_len : operr_r;
      latch_r    <= go_err | (latch_r &
                    ~(wr_stat & hwdata[checksum_pkg::ST_LATCH]));
      errcode_r  <= go_err ? checksum_pkg::ERR_LEN_CODE : errcode_r;
      result_r   <= done_ev ? res_w : result_r;
      int_stat_r <= int_nxt;
      irq_r      <= |(int_nxt & mask_nxt);
    end
  end

  // ------------------------------------------------------------------
  // engine
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= checksum_pkg::IDLE;
      mode8_r <= 1'b0;
      rtu_r   <= 1'b0;
      end_r   <= 1'b0;
      cnt_r   <= 9'h000;
      crc_r   <= checksum_pkg::CRC_INIT;
      sum_r   <= 8'h00;
      nib_r   <= 4'h0;
      ph_r    <= 1'b0;
      k_r     <= 2'd0;
    end else begin
      case (state_r)
        checksum_pkg::IDLE: begin
          if (go_run) begin
            state_r <= checksum_pkg::RUN;
            mode8_r <= hwdata[checksum_pkg::CTRL_BYTE];
            rtu_r   <= hwdata[checksum_pkg::CTRL_RTU];
            end_r   <= hwdata[checksum_pkg::CTRL_END];
            cnt_r   <= 9'h000;
            crc_r   <= checksum_pkg::CRC_INIT;
            sum_r   <= 8'h00;
            ph_r    <= 1'b0;
            k_r     <= 2'd0;
          end
        end
        checksum_pkg::RUN: begin
          // one byte per clock through the selected check
          if (rtu_r) begin
            crc_r <= crc_nxt;
          end else begin
            sum_r <= sum_nxt;
            nib_r <= nib_nxt;
            ph_r  <= ph_nxt;
          end
          cnt_r   <= cnt_r + 9'h001;
          state_r <= last ? checksum_pkg::STORE : checksum_pkg::RUN;
        end
        checksum_pkg::STORE: begin
          k_r     <= k_r + 2'd1;
          state_r <= (k_r == k_last) ? checksum_pkg::IDLE
                                     : checksum_pkg::STORE;
        end
        default: state_r <= checksum_pkg::IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = irq_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bad_len_error: assert property (go_err |=> operr_r && latch_r &&
    errcode_r == checksum_pkg::ERR_LEN_CODE && state_r == checksum_pkg::IDLE)
    else $error("bad length did not raise the error flags");
  a_good_len_runs: assert property (go_run |=>
    state_r == checksum_pkg::RUN && crc_r == checksum_pkg::CRC_INIT &&
    !operr_r)
    else $error("good length did not start the engine");
  a_run_ends_store: assert property (state_r == checksum_pkg::RUN &&
    last |=> state_r == checksum_pkg::STORE && cnt_r == $past(len_r))
    else $error("run did not end after the byte count");
  a_crc_low_first: assert property (eng_we && rtu_r && mode8_r &&
    k_r == 2'd0 |-> eng_wdata[7:0] == crc_r[7:0] ##1
    eng_wdata[7:0] == crc_r[15:8])
    else $error("crc bytes stored in wrong order");
  a_crc_packed: assert property (eng_we && rtu_r && !mode8_r |->
    eng_wdata == {crc_r[7:0], crc_r[15:8]})
    else $error("packed crc word wrong");
  a_lrc_hex_hi: assert property (eng_we && !rtu_r && !mode8_r &&
    k_r == 2'd0 |->
    eng_wdata == {checksum_pkg::hex_enc(lrc_val[7:4]),
                  checksum_pkg::hex_enc(lrc_val[3:0])})
    else $error("lrc characters wrong");
  a_lrc_sum_neg: assert property (done_ev && !rtu_r |=>
    result_r[7:0] + $past(sum_r) == 8'h00)
    else $error("lrc is not the negated sum");
  a_irq_follows: assert property (irq_r == |(int_stat_r & int_mask_r))
    else $error("irq does not follow masked status");
  a_set_wins: assert property (done_ev |=> int_stat_r[checksum_pkg::INT_DONE])
    else $error("done event lost under read clear");
  a_store_bounded: assert property ($rose(state_r == checksum_pkg::STORE)
    |-> ##[1:4] state_r == checksum_pkg::IDLE)
    else $error("store phase too long");
  a_odd_len_skips: assert property (start && len_r[0] |=>
    state_r == checksum_pkg::IDLE && operr_r)
    else $error("odd length did not stop the operation");
  a_lrc_end_pair: assert property (eng_we && !rtu_r && end_r && mode8_r &&
    k_r == 2'd3 |-> eng_wdata == {8'h00, checksum_pkg::CHAR_LF})
    else $error("line feed not stored last");

  c_crc_done:  cover property (done_ev && rtu_r && mode8_r);
  c_lrc_frame: cover property (done_ev && !rtu_r && end_r);
  c_len_error: cover property (go_err);
  c_irq_rise:  cover property ($rose(irq_r));
endmodule // frame_checksum_unit

// ==== checksum_pkg.sv ====
/*
  constants, register map and shared helpers of the serial frame checksum
  unit. assumes a 32-bit ahb-lite register bus and 16-bit storage words.
*/
package checksum_pkg;
  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] LEN_ADDR     = 12'h004;
  localparam logic [11:0] SRC_ADDR     = 12'h008;
  localparam logic [11:0] DST_ADDR     = 12'h00c;
  localparam logic [11:0] STATUS_ADDR  = 12'h010;
  localparam logic [11:0] ERRCODE_ADDR = 12'h014;
  localparam logic [11:0] RESULT_ADDR  = 12'h018;
  localparam logic [11:0] INTSTAT_ADDR = 12'h01c;
  localparam logic [11:0] INTMASK_ADDR = 12'h020;
  localparam int          MEM_SEL_BIT  = 11;     // 0x800..0xffc word store
  localparam int          MEM_WORDS    = 512;
  localparam int          IDX_W        = 9;
  // ------------------------------------------------------------------
  // fields
  // ------------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_BYTE  = 1;                 // byte_mode_select
  localparam int CTRL_RTU   = 2;                 // rtu_mode_select
  localparam int CTRL_END   = 3;                 // append cr lf
  localparam int ST_BUSY    = 0;
  localparam int ST_OPERR   = 1;                 // operation_error_flag
  localparam int ST_LATCH   = 2;                 // error_latch_flag
  localparam int INT_DONE   = 0;
  localparam int INT_ERR    = 1;
  // ------------------------------------------------------------------
  // values
  // ------------------------------------------------------------------
  localparam logic [15:0] ERR_LEN_CODE = 16'h0e1a;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;
  localparam logic [8:0]  LEN_MAX      = 9'h100;
  localparam logic [7:0]  CHAR_START   = 8'h3a;
  localparam logic [7:0]  CHAR_CR      = 8'h0d;
  localparam logic [7:0]  CHAR_LF      = 8'h0a;
  localparam logic [7:0]  CHAR_ZERO    = 8'h30;
  localparam logic [7:0]  CHAR_A_OFS   = 8'h37;  // 'A' minus ten
  localparam logic [7:0]  CHAR_LA_OFS  = 8'h57;  // 'a' minus ten
  localparam logic [7:0]  CHAR_LOW_A   = 8'h61;
  localparam logic [7:0]  CHAR_UP_A    = 8'h41;
  localparam logic [3:0]  NIB_TEN      = 4'ha;

  typedef enum logic [1:0] {IDLE, RUN, STORE} eng_state_t;

  // nibble to upper-case hex character
  function automatic logic [7:0] hex_enc(input logic [3:0] n);
    hex_enc = (n < NIB_TEN) ? CHAR_ZERO + {4'h0, n} : CHAR_A_OFS + {4'h0, n};
  endfunction

  // hex character to nibble, either case
  function automatic logic [3:0] hex_dec(input logic [7:0] c);
    logic [7:0] v;
    v = (c >= CHAR_LOW_A) ? c - CHAR_LA_OFS :
        (c >= CHAR_UP_A)  ? c - CHAR_A_OFS  : c - CHAR_ZERO;
    hex_dec = v[3:0];
  endfunction
endpackage

// ==== crc16_step.sv ====
/*
  one byte of the reflected 16-bit crc update, purely combinational.
  assumes the caller holds the running value in a register.
*/
`timescale 1ns/100ps
module crc16_step (
  input  wire logic [15:0] crc_in,   // running value
  input  wire logic [7:0]  data_in,  // next byte
  output logic      [15:0] crc_out   // updated value
);
  // ------------------------------------------------------------------
  // eight shifts, lsb first
  // ------------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ checksum_pkg::CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule // crc16_step

// ==== lrc_step.sv ====
/*
  one character of the longitudinal check: pairs hex characters into
  bytes, high nibble first, and sums the bytes. a start character
  restarts the sum. assumes the caller registers all outputs.
*/
`timescale 1ns/100ps
module lrc_step (
  input  wire logic [7:0] char_in,   // ascii character
  input  wire logic [7:0] sum_in,    // running byte sum
  input  wire logic [3:0] nib_in,    // held high nibble
  input  wire logic       phase_in,  // high nibble already held
  output logic      [7:0] sum_out,   // new sum
  output logic      [3:0] nib_out,   // new held nibble
  output logic            phase_out  // new phase
);
  wire logic       is_start = (char_in == checksum_pkg::CHAR_START);
  wire logic [3:0] nib      = checksum_pkg::hex_dec(char_in);

  // start char clears, first char holds, second char adds the byte
  assign sum_out   = is_start ? 8'h00 :
                     phase_in ? sum_in + {nib_in, nib} :
                     sum_in;
  assign nib_out   = nib;
  assign phase_out = is_start ? 1'b0 : ~phase_in;
endmodule // lrc_step

// ==== drive_model.sv ====
/*
  motor drive model: the request frames that the attached drive accepts.
  assumes the bench slices bytes out of the flat vectors, first in msbs.
*/
`timescale 1ns/100ps
module drive_model (
  output logic [135:0] txt_frame,  // text frame, 17 characters
  output logic [63:0]  rtu_frame   // binary frame, 8 bytes
);
  // ------------------------------------------------------------------
  // text frame: start, address, function, data, check, end pair
  // ------------------------------------------------------------------
  assign txt_frame = {8'h3a,
                      "01",
                      "03",
                      "21020002",
                      "D7",
                      8'h0d,
                      8'h0a};
  // binary frame, crc low byte goes out first
  assign rtu_frame = 64'h01060706177066ab;
endmodule // drive_model

// ==== tb_serial_frame_checksum_unit.sv ====
/*
  testbench of the frame checksum unit: ahb-lite register tasks.
  assumes a single slave, so hready is fed back from hreadyout.
*/
`timescale 1ns/100ps
module tb_serial_frame_checksum_unit;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata, r;
  logic         hreadyout, hresp, irq;
  logic [135:0] txt;
  logic [63:0]  rtu;
  int           failures = 0;
  int           checked = 0;
  logic [3:0]   op_ctrl [4] = '{4'hb, 4'h7, 4'h9, 4'h5};
  logic [8:0]   op_len [4] = '{9'h00c, 9'h006, 9'h00c, 9'h006};
  logic [8:0]   op_src [4] = '{9'h001, 9'h014, 9'h020, 9'h028};
  logic [15:0]  op_res [4] = '{16'h00d7, 16'hab66, 16'h00d7, 16'hab66};
  logic [15:0]  op_exp [4][4] = '{'{16'h0044, 16'h0037, 16'h000d,
    16'h000a}, '{16'h0066, 16'h00ab, 16'h0, 16'h0}, '{16'h4437,
    16'h0d0a, 16'h0, 16'h0}, '{16'h66ab, 16'h0, 16'h0, 16'h0}};
  int           op_n [4] = '{4, 2, 2, 1};
  logic [8:0]   bad_len [3] = '{9'h000, 9'h005, 9'h101};

  // ------------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------------
  always #10 hclk = ~hclk;

  frame_checksum_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  drive_model far_u (.txt_frame(txt), .rtu_frame(rtu));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] ch(int i);
    ch = txt[8*(16-i) +: 8];
  endfunction
  function automatic logic [7:0] rb(int i);
    rb = rtu[8*(7-i) +: 8];
  endfunction
  function automatic logic [31:0] sa(int i);
    sa = 32'h800 + 32'(i) * 32'h4;
  endfunction
  function automatic logic [31:0] ra(logic [11:0] a);
    ra = {20'h0, a};
  endfunction

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    q = hrdata;
    if (n >= 99) begin
      failures++;
      report_and_stop;
    end
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] exp, string name);
    xfer(1'b0, a, 32'h0, r);
    check(name, r, exp);
  endtask

  // start one operation, poll until idle, check results and irq
  task automatic run_op(int i);
    int n;
    wr(ra(checksum_pkg::LEN_ADDR), {23'h0, op_len[i]});
    wr(ra(checksum_pkg::SRC_ADDR), {23'h0, op_src[i]});
    wr(ra(checksum_pkg::DST_ADDR), 32'(100 + 10 * i));
    wr(ra(checksum_pkg::CTRL_ADDR), {28'h0, op_ctrl[i]});
    wr(ra(checksum_pkg::LEN_ADDR), 32'h1fe); // dropped while busy
    n = 0;
    do begin xfer(1'b0, ra(checksum_pkg::STATUS_ADDR), 32'h0, r); n++; end
    while (r[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      failures++;
      report_and_stop;
    end
    @(posedge hclk);
    #1 check("irq done", {31'h0, irq}, 32'h1);
    rd(ra(checksum_pkg::STATUS_ADDR), 32'h0, "status");
    rd(ra(checksum_pkg::RESULT_ADDR), {16'h0, op_res[i]}, "result");
    rd(ra(checksum_pkg::LEN_ADDR), {23'h0, op_len[i]}, "len held");
    rd(ra(checksum_pkg::SRC_ADDR), {23'h0, op_src[i]}, "src");
    rd(ra(checksum_pkg::DST_ADDR), 32'(100 + 10 * i), "dst reg");
    for (int k = 0; k < op_n[i]; k++) begin
      rd(sa(100 + 10 * i + k), {16'h0, op_exp[i][k]}, "dst");
    end
    rd(ra(checksum_pkg::INTSTAT_ADDR), 32'h1, "int done");
    @(posedge hclk);
    #1 check("irq clear", {31'h0, irq}, 32'h0);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ra(checksum_pkg::STATUS_ADDR), 32'h0, "status reset");
    rd(ra(checksum_pkg::INTSTAT_ADDR), 32'h0, "intstat reset");
    rd(ra(checksum_pkg::CTRL_ADDR), 32'h0, "ctrl reset");
    rd(32'h40, 32'h0, "unmapped");
    check("hresp", {31'h0, hresp}, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    // text chars one per word, binary bytes one per word, then packed
    for (int i = 0; i < 17; i++) wr(sa(i), {24'h0, ch(i)});
    for (int i = 0; i < 8; i++) wr(sa(20 + i), {24'h0, rb(i)});
    for (int i = 0; i < 6; i++) wr(sa(32 + i), {16'h0, ch(1+2*i), ch(2+2*i)});
    for (int i = 0; i < 3; i++) wr(sa(40 + i), {16'h0, rb(2*i), rb(2*i+1)});
    // zero, odd and oversize counts, interrupts masked
    for (int i = 0; i < 3; i++) begin
      wr(ra(checksum_pkg::LEN_ADDR), {23'h0, bad_len[i]});
      wr(ra(checksum_pkg::CTRL_ADDR), 32'h5);
      rd(ra(checksum_pkg::STATUS_ADDR), 32'h6, "err flags");
      rd(ra(checksum_pkg::ERRCODE_ADDR), 32'h0e1a, "err code");
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(ra(checksum_pkg::INTSTAT_ADDR), 32'h2, "int err");
      rd(ra(checksum_pkg::INTSTAT_ADDR), 32'h0, "int cleared");
    end
    wr(ra(checksum_pkg::STATUS_ADDR), 32'h4);
    rd(ra(checksum_pkg::STATUS_ADDR), 32'h2, "latch cleared");
    wr(ra(checksum_pkg::INTMASK_ADDR), 32'h3);
    // lrc byte mode, crc byte mode, lrc packed, crc packed
    for (int i = 0; i < 4; i++) begin
      run_op(i);
    end
    rd(ra(checksum_pkg::CTRL_ADDR), 32'h4, "ctrl bits");
    report_and_stop;
  end
endmodule // tb_serial_frame_checksum_unit
